// ===== verilog/sro_defs.svh
// Constants for the serial readout block of the successive-approximation core.
`ifndef SRO_DEFS_SVH
`define SRO_DEFS_SVH

`define SRO_RESULT_WIDTH 18
`define SRO_FIFO_DEPTH 16
`define SRO_CLK_MHZ 25
`define SRO_CONV_TIME_NS 1500
`define SRO_CONV_CYCLES ((`SRO_CONV_TIME_NS * `SRO_CLK_MHZ + 999) / 1000)
`define SRO_BUSY_FALLS 19
`define SRO_PLAIN_FALLS 18
`define SRO_BUSY_BIT_CS 1'h0
`define SRO_BUSY_BIT_CHAIN 1'h1

`endif

// ===== verilog/sro_pkg.sv
// Types used only by the serial readout block, not by its result buffer.
package sro_pkg;

    typedef enum logic [2:0] {
        SRO_ACQ  = 3'b001,
        SRO_CONV = 3'b010,
        SRO_SHDN = 3'b100
    } sro_state_t;

    typedef struct packed {
        logic trig;
        logic sclk;
        logic sel;
    } sro_pins_t;

endpackage : sro_pkg

// ===== verilog/sro_fifo.sv
// Result buffer between the conversion core and the serial readout.
`timescale 1ns/1ps
module sro_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule : sro_fifo

// ===== verilog/sro_readout.sv
// Serial readout, mode selection and shutdown of the converter interface.
//
// How it works
// - Select input at trigger rise picks mode.
// - Select tied to trigger gives chain mode.
// - Chip-select busy when trigger/select low at end.
// - Chain busy follows shift clock at rise.
// - Busy bit precedes data, flushed by one clock.
// - Output bit holds across rising clock edge.
// - Chip-select: unread bits go out before new ones.
// - Trigger fall, clock high: enter shutdown.
// - Trigger fall, clock low: leave shutdown.
// - Chip-select rise starts conversion, output floats.
// - Conversion completes regardless of trigger level.
// - Trigger fall shows MSB, falls shift on.
// - No busy: float after eighteenth falling edge.
// - Busy: output driven low at conversion end.
// - Busy: float after nineteenth edge or trigger and select both high.
// - Result is 18-bit straight binary code.
// - Chain input shifts through like one register.
// - Chain without busy: MSB first, 18N edges.
// - Chain busy bit not passed, 18N+1 edges.
// - Four-wire readout starts with select low.
`timescale 1ns/1ps
`include "sro_defs.svh"
module sro_readout #(
    parameter int W = `SRO_RESULT_WIDTH,
    parameter int DEPTH = `SRO_FIFO_DEPTH,
    parameter int CONV_CYCLES = `SRO_CONV_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CONVERSION_TRIGGER,
    input wire logic SHIFT_CLOCK,
    input wire logic CHAIN_SELECT_INPUT,
    input wire logic [W-1:0] RESULT_DATA,
    input wire logic RESULT_VALID,
    output logic RESULT_READY,
    output logic SERIAL_RESULT_OUTPUT,
    output logic SERIAL_RESULT_OUTPUT_OE,
    output logic CONV_START,
    output logic CONV_ACTIVE,
    output logic SHUTDOWN,
    output logic CHAIN_MODE,
    output logic BUSY_ENABLED
);
    localparam int SW = 2 * W;
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int LW = $clog2(SW + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam logic [LW-1:0] W_L = LW'(W);
    localparam logic [LW-1:0] SW_L = LW'(SW);
    localparam logic [5:0] BUSY_LIM = 6'(`SRO_BUSY_FALLS);
    localparam logic [5:0] PLAIN_LIM = 6'(`SRO_PLAIN_FALLS);

    sro_pkg::sro_pins_t pin_m_reg;
    sro_pkg::sro_pins_t pin_s_reg;
    sro_pkg::sro_pins_t pin_d_reg;
    sro_pkg::sro_state_t state_reg;
    logic [CW-1:0] cnt_reg;
    logic chain_reg;
    logic busy_reg;
    logic busy_pend_reg;
    logic [SW-1:0] sr_reg;
    logic [LW-1:0] left_reg;
    logic [5:0] falls_reg;
    logic sdo_reg;
    logic oe_reg;
    logic start_reg;

    logic trig_rise;
    logic trig_fall;
    logic sclk_fall;
    logic cs_active;
    logic conv_done;
    logic out_done;
    logic shift_ok;
    logic busy_next;
    logic sdo_next;
    logic oe_next;
    logic [5:0] fall_lim;
    logic [W-1:0] fifo_data;
    logic fifo_valid;

    // Every pin passes two flops; the third stage gives edge history and the select/clock levels read at a trigger edge.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pin_m_reg <= '0;
            pin_s_reg <= '0;
            pin_d_reg <= '0;
        end else begin
            pin_m_reg <= {CONVERSION_TRIGGER, SHIFT_CLOCK, CHAIN_SELECT_INPUT};
            pin_s_reg <= pin_m_reg;
            pin_d_reg <= pin_s_reg;
        end
    end

    assign trig_rise = pin_s_reg.trig & ~pin_d_reg.trig;
    assign trig_fall = ~pin_s_reg.trig & pin_d_reg.trig;
    assign sclk_fall = ~pin_s_reg.sclk & pin_d_reg.sclk;

    sro_fifo #(
        .WIDTH(W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .in_data(RESULT_DATA),
        .in_valid(RESULT_VALID),
        .in_ready(RESULT_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(conv_done)
    );

    // A conversion only finishes once the core has delivered its word.
    assign conv_done = (state_reg == sro_pkg::SRO_CONV)
        && (cnt_reg == CONV_LAST) && fifo_valid;
    // Select and trigger both high means the chip-select readout is idle.
    assign cs_active = ~(pin_s_reg.trig & pin_s_reg.sel);
    assign fall_lim = busy_pend_reg || busy_reg ? BUSY_LIM : PLAIN_LIM;
    assign out_done = (falls_reg >= fall_lim);
    assign busy_next = ~pin_s_reg.trig | ~pin_s_reg.sel;
    assign shift_ok = (state_reg == sro_pkg::SRO_ACQ)
        && (chain_reg || (cs_active && !out_done));

    // The level seen one cycle before the rise is used, so a select pin
    // wired to the trigger reads low and lands in chain mode.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= sro_pkg::SRO_ACQ;
            cnt_reg <= '0;
            chain_reg <= 1'b0;
            busy_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            unique case (state_reg)
                sro_pkg::SRO_ACQ: begin
                    if (trig_rise) begin
                        state_reg <= sro_pkg::SRO_CONV;
                        cnt_reg <= '0;
                        start_reg <= 1'b1;
                        chain_reg <= ~pin_d_reg.sel;
                        if (!pin_d_reg.sel) begin
                            busy_reg <= pin_d_reg.sclk;
                        end
                    end else if (trig_fall && pin_d_reg.sclk) begin
                        state_reg <= sro_pkg::SRO_SHDN;
                    end
                end
                sro_pkg::SRO_CONV: begin
                    // The trigger is only read here for the chip-select busy choice.
                    if (cnt_reg != CONV_LAST) begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end else if (conv_done) begin
                        state_reg <= sro_pkg::SRO_ACQ;
                        if (!chain_reg) begin
                            busy_reg <= busy_next;
                        end
                    end
                end
                sro_pkg::SRO_SHDN: begin
                    if (trig_fall && !pin_d_reg.sclk) begin
                        state_reg <= sro_pkg::SRO_ACQ;
                    end
                end
                default: begin
                    state_reg <= sro_pkg::SRO_ACQ;
                end
            endcase
        end
    end

    // The result word is MSB aligned; in chip-select mode bits still unread from the last cycle
    // stay on top and the new word is appended below them.  Only two words
    // fit, so a third unread word pushes the newest bits off the end.
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sr_reg <= '0;
            left_reg <= '0;
            busy_pend_reg <= 1'b0;
            falls_reg <= '0;
        end else if (conv_done) begin
            falls_reg <= '0;
            busy_pend_reg <= chain_reg ? busy_reg : busy_next;
            if (chain_reg) begin
                sr_reg <= {fifo_data, {W{1'b0}}};
                left_reg <= W_L;
            end else begin
                sr_reg <= sr_reg
                    | ({fifo_data, {W{1'b0}}} >> left_reg);
                left_reg <= (left_reg > W_L) ? SW_L : left_reg + W_L;
            end
        end else if (trig_rise && chain_reg
            && state_reg == sro_pkg::SRO_ACQ) begin
            // Chain mode never keeps leftovers, so a chip-select cycle that
            // follows a chain cycle must not see the upstream bits as unread.
            sr_reg <= '0;
            left_reg <= '0;
        end else if (sclk_fall && shift_ok) begin
            if (falls_reg != 6'h3F) begin
                falls_reg <= falls_reg + 6'h01;
            end
            if (busy_pend_reg) begin
                busy_pend_reg <= 1'b0;
            end else if (chain_reg) begin
                // The upstream bit takes the slot freed at the bottom.
                sr_reg <= {sr_reg[SW-2:0], 1'b0}
                    | (SW'(pin_s_reg.sel) << (SW_L - left_reg));
            end else if (left_reg != '0) begin
                sr_reg <= {sr_reg[SW-2:0], 1'b0};
                left_reg <= left_reg - 1'b1;
            end
        end
    end

    // Output value and enable are decided here and held in flops, so a bit
    // only moves on a falling shift edge and stays put across the rising one.
    always_comb begin
        sdo_next = sr_reg[SW-1];
        oe_next = 1'b0;
        unique case (state_reg)
            sro_pkg::SRO_SHDN: begin
                sdo_next = 1'b0;
                oe_next = 1'b0;
            end
            sro_pkg::SRO_CONV: begin
                sdo_next = 1'b0;
                oe_next = chain_reg;
            end
            sro_pkg::SRO_ACQ: begin
                if (chain_reg) begin
                    oe_next = 1'b1;
                    if (busy_pend_reg) begin
                        sdo_next = `SRO_BUSY_BIT_CHAIN;
                    end
                end else if (busy_pend_reg) begin
                    sdo_next = `SRO_BUSY_BIT_CS;
                    oe_next = cs_active;
                end else begin
                    oe_next = cs_active && !out_done
                        && (left_reg != '0);
                end
            end
            default: begin
                sdo_next = 1'b0;
                oe_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            sdo_reg <= sdo_next;
            oe_reg <= oe_next;
        end
    end

    assign SERIAL_RESULT_OUTPUT = sdo_reg;
    assign SERIAL_RESULT_OUTPUT_OE = oe_reg;
    assign CONV_START = start_reg;
    assign CONV_ACTIVE = (state_reg == sro_pkg::SRO_CONV);
    assign SHUTDOWN = (state_reg == sro_pkg::SRO_SHDN);
    assign CHAIN_MODE = chain_reg;
    assign BUSY_ENABLED = busy_reg;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    a_mode_select: assert property (
        (state_reg == sro_pkg::SRO_ACQ && trig_rise)
        |=> (chain_reg == !$past(pin_d_reg.sel)))
        else $error("mode not taken from select level at trigger rise");

    a_tied_chain: assert property (
        (state_reg == sro_pkg::SRO_ACQ && trig_rise
            && pin_d_reg.sel == pin_d_reg.trig)
        |=> chain_reg)
        else $error("select tied to trigger did not give chain mode");

    a_cs_busy: assert property (
        (conv_done && !chain_reg)
        |=> (busy_reg == $past(busy_next)) && busy_pend_reg == busy_reg)
        else $error("chip-select busy choice wrong at conversion end");

    a_chain_busy: assert property (
        (state_reg == sro_pkg::SRO_ACQ && trig_rise && !pin_d_reg.sel)
        |=> (busy_reg == $past(pin_d_reg.sclk)))
        else $error("chain busy choice not taken from shift clock");

    a_busy_flush: assert property (
        (busy_pend_reg && sclk_fall && shift_ok && !conv_done)
        |=> !busy_pend_reg && (sr_reg == $past(sr_reg)))
        else $error("busy bit flush moved the data");

    a_keep_unread: assert property (
        (conv_done && !chain_reg && left_reg != '0)
        |=> (sr_reg[SW-1] == $past(sr_reg[SW-1])))
        else $error("unread bit lost when new result loaded");

    a_shut_enter: assert property (
        (state_reg == sro_pkg::SRO_ACQ && trig_fall && pin_d_reg.sclk)
        |=> SHUTDOWN ##1 !oe_reg)
        else $error("shutdown not entered or output still driven");

    a_shut_leave: assert property (
        (SHUTDOWN && trig_fall && !pin_d_reg.sclk)
        |=> (state_reg == sro_pkg::SRO_ACQ))
        else $error("shutdown not left on trigger fall with clock low");

    a_conv_float: assert property (
        (CONV_ACTIVE && !chain_reg) |=> !oe_reg)
        else $error("output driven during chip-select conversion");

    a_conv_runs: assert property (
        (CONV_ACTIVE && cnt_reg != CONV_LAST)
        |=> CONV_ACTIVE && (cnt_reg == $past(cnt_reg) + 1'b1))
        else $error("conversion cut short");

    a_read_limit: assert property (
        (state_reg == sro_pkg::SRO_ACQ && !chain_reg
            && falls_reg >= fall_lim && !conv_done)
        |=> !oe_reg)
        else $error("output still driven after last falling edge");

    a_busy_low: assert property (
        (conv_done && !chain_reg && busy_next && cs_active)
        |=> ##1 (oe_reg && !sdo_reg))
        else $error("busy bit not driven low at conversion end");

    c_cs_read: cover property (
        conv_done && !chain_reg && !busy_next ##[1:200] oe_reg);
    c_cs_busy: cover property (conv_done && !chain_reg && busy_next);
    c_chain_busy: cover property (conv_done && chain_reg && busy_reg);
    c_shutdown: cover property (SHUTDOWN ##[1:500] !SHUTDOWN);

endmodule : sro_readout

// ===== bench/sro_host.sv
// Host model that drives the converter pins and captures the serial line.
`timescale 1ns/1ps
module sro_host (
    input wire logic clk,
    input wire logic serial_result_output,
    input wire logic oe,
    output logic trig,
    output logic sclk,
    output logic sel
);
    // A floating output reads high through the external pull-up.
    wire line = oe ? serial_result_output : 1'b1;

    initial begin
        trig = 1'b0;
        sclk = 1'b0;
        sel = 1'b1;
    end

    // Each level stands at least 200 ns, so nothing moves near a trigger rise.
    task pins(input logic t, input logic c,
        input logic s);
        @(negedge clk);
        trig = t;
        sclk = c;
        sel = s;
        repeat (4) @(negedge clk);
    endtask : pins

    // One 360 ns shift period, 160 ns high; the bit is taken just before the fall.
    task shift(input logic s, output logic b);
        @(negedge clk);
        sclk = 1'b1;
        sel = s;
        repeat (4) @(negedge clk);
        b = line;
        sclk = 1'b0;
        repeat (4) @(negedge clk);
    endtask : shift
endmodule : sro_host

// ===== bench/sro_readout_tb.sv
// Self-checking bench for the serial readout block.
`timescale 1ns/1ps
`include "sro_defs.svh"
module sro_readout_tb;
    localparam int CC = 12;
    logic clk;
    logic rst_n;
    logic [17:0] result_data;
    logic result_valid;
    logic result_ready;
    logic serial_result_output;
    logic oe;
    logic conv_start;
    logic conv_active;
    logic shutdown;
    logic chain_mode;
    logic busy_enabled;
    wire trig;
    wire sclk;
    wire sel;
    int bad_count = 0;
    int n_tests = 0;
    int n_start = 0;
    int n_conv = 0;
    logic was_chain = 1'b0;
    logic [17:0] wq[$];
    logic bq[$];

    sro_readout #(.CONV_CYCLES(CC)) i_dut (
        .CLK_SYS(clk), .RSTN(rst_n), .CONVERSION_TRIGGER(trig),
        .SHIFT_CLOCK(sclk), .CHAIN_SELECT_INPUT(sel),
        .RESULT_DATA(result_data), .RESULT_VALID(result_valid),
        .RESULT_READY(result_ready), .SERIAL_RESULT_OUTPUT(serial_result_output),
        .SERIAL_RESULT_OUTPUT_OE(oe), .CONV_START(conv_start),
        .CONV_ACTIVE(conv_active), .SHUTDOWN(shutdown),
        .CHAIN_MODE(chain_mode), .BUSY_ENABLED(busy_enabled)
    );

    sro_host i_host (.clk(clk), .serial_result_output(serial_result_output), .oe(oe), .trig(trig),
        .sclk(sclk), .sel(sel));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_start === 1'b1) n_start <= n_start + 1;
    end

    task test_done;
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task chkw(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkw

    task push(input logic [17:0] w);
        @(negedge clk);
        chk1(result_ready, 1'b1);
        result_data = w;
        result_valid = 1'b1;
        wq.push_back(w);
    endtask : push

    // Chain mode reloads its register, so leftovers are dropped whenever a
    // chain cycle begins or the one before was a chain cycle.
    task conv(input logic chain);
        logic [17:0] w;
        if (chain || was_chain) bq.delete();
        was_chain = chain;
        w = wq.pop_front();
        for (int i = 17; i >= 0; i--) bq.push_back(w[i]);
        n_conv++;
    endtask : conv

    task idle;
        int k;
        k = 0;
        while (conv_active !== 1'b0 && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k >= 300) begin
            bad_count++;
            test_done;
        end
        repeat (4) @(negedge clk);
    endtask : idle

    task rd(input int n, input logic chain, input logic [35:0] pat);
        logic b;
        for (int i = 0; i < n; i++) begin
            i_host.shift(pat[35 - i], b);
            if (chain) bq.push_back(pat[35 - i]);
            chk1(b, bq.pop_front());
        end
        repeat (4) @(negedge clk);
    endtask : rd

    initial begin
        rst_n = 1'b0;
        result_data = 18'h00000;
        result_valid = 1'b0;
        repeat (10) @(negedge clk);
        chk1(result_ready, 1'b1);
        chk1(oe, 1'b0);
        rst_n = 1'b1;
        push(18'h3FFFF);
        push(18'h20000);
        push(18'h00000);
        for (int i = 3; i < 16; i++) push(18'h2A5A5 ^ 18'(i * 32'h0000137B));
        @(negedge clk);
        result_valid = 1'b0;
        chk1(result_ready, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b0);
        chk1(oe, 1'b0);
        idle;
        chk1(chain_mode, 1'b0);
        chk1(busy_enabled, 1'b0);
        i_host.pins(1'b0, 1'b0, 1'b1);
        chk1(oe, 1'b1);
        rd(18, 1'b0, '1);
        chk1(oe, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b0);
        i_host.pins(1'b0, 1'b0, 1'b1);
        idle;
        chk1(busy_enabled, 1'b1);
        chk1(oe, 1'b1);
        chk1(serial_result_output, 1'b0);
        bq.push_front(`SRO_BUSY_BIT_CS);
        rd(19, 1'b0, '1);
        chk1(oe, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b0);
        idle;
        i_host.pins(1'b0, 1'b0, 1'b1);
        rd(10, 1'b0, '1);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b0);
        chk1(oe, 1'b0);
        idle;
        i_host.pins(1'b1, 1'b0, 1'b0);
        rd(18, 1'b0, 36'h000000000);
        chk1(oe, 1'b0);
        i_host.pins(1'b0, 1'b0, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b0);
        conv(1'b1);
        chk1(chain_mode, 1'b1);
        chk1(busy_enabled, 1'b0);
        idle;
        rd(36, 1'b1, 36'h0F0F3C3A5);
        chk1(oe, 1'b1);
        i_host.pins(1'b0, 1'b0, 1'b0);
        i_host.pins(1'b0, 1'b1, 1'b0);
        i_host.pins(1'b1, 1'b1, 1'b0);
        conv(1'b1);
        chk1(busy_enabled, 1'b1);
        idle;
        bq.push_front(`SRO_BUSY_BIT_CHAIN);
        rd(19, 1'b1, 36'h5A5A5A5A5);
        i_host.pins(1'b0, 1'b0, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b1);
        chk1(chain_mode, 1'b1);
        idle;
        i_host.pins(1'b1, 1'b1, 1'b1);
        i_host.pins(1'b0, 1'b1, 1'b1);
        chk1(shutdown, 1'b1);
        chk1(oe, 1'b0);
        i_host.pins(1'b1, 1'b1, 1'b1);
        chkw(18'(n_start), 18'(n_conv));
        i_host.pins(1'b1, 1'b0, 1'b1);
        i_host.pins(1'b0, 1'b0, 1'b1);
        chk1(shutdown, 1'b0);
        for (int i = 0; i < 9; i++) begin
            i_host.pins(1'b0, 1'b0, 1'b0);
            i_host.pins(1'b1, 1'b0, 1'b0);
            conv(1'b1);
            idle;
        end
        chk1(result_ready, 1'b1);
        i_host.pins(1'b0, 1'b0, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b0);
        // An empty buffer must hold the conversion open.
        repeat (40) @(negedge clk);
        chk1(conv_active, 1'b1);
        push(18'h1C3E5);
        @(negedge clk);
        result_valid = 1'b0;
        conv(1'b1);
        idle;
        rd(18, 1'b1, 36'h000000000);
        // Back to chip-select after chain mode, 4-wire with busy bit.
        push(18'h0A5C3);
        @(negedge clk);
        result_valid = 1'b0;
        i_host.pins(1'b0, 1'b0, 1'b1);
        i_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b0);
        chk1(chain_mode, 1'b0);
        i_host.pins(1'b1, 1'b0, 1'b0);
        idle;
        chk1(busy_enabled, 1'b1);
        chk1(oe, 1'b1);
        chk1(serial_result_output, 1'b0);
        bq.push_front(`SRO_BUSY_BIT_CS);
        rd(19, 1'b0, 36'h000000000);
        chk1(oe, 1'b0);
        chkw(18'(n_start), 18'(n_conv));
        test_done;
    end
endmodule : sro_readout_tb
